/* verilog/lwd_defs.vh */
// constants for the lin wake and dominant timeout supervisor
`ifndef LWD_DEFS_VH
`define LWD_DEFS_VH

// modes
`define LWD_MODE_OFF     2'h0
`define LWD_MODE_NORMAL  2'h1
`define LWD_MODE_LOWPWR  2'h2
`define LWD_MODE_STANDBY 2'h3

// internal time base: 200 MHz clock, 1 us tick
`define LWD_CLK_MHZ      200
`define LWD_TICK_US      1
`define LWD_TICK_CYC     (`LWD_CLK_MHZ * `LWD_TICK_US)

// times in microseconds (plain defaults)
`define LWD_WAKE_DOM_US  80
`define LWD_LOC_WAKE_US  50
`define LWD_SLEEP_US     20
`define LWD_TXD_TO_US    20000
`define LWD_BUS_TO_US    20000
// counts in ticks
`define LWD_WAKE_DOM_TK  (`LWD_WAKE_DOM_US / `LWD_TICK_US)
`define LWD_LOC_WAKE_TK  ((`LWD_LOC_WAKE_US + `LWD_TICK_US - 1) / `LWD_TICK_US)
`define LWD_SLEEP_TK     (`LWD_SLEEP_US / `LWD_TICK_US)
`define LWD_TXD_TO_TK    (`LWD_TXD_TO_US / `LWD_TICK_US)
`define LWD_BUS_TO_TK    (`LWD_BUS_TO_US / `LWD_TICK_US)

// fifo geometry
`define LWD_FIFO_W       4
`define LWD_FIFO_D       8

`endif

/* verilog/lwd_fifo.v */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lwd_fifo #(
  parameter WIDTH = 4,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             rst_n_in,
  // write side
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  // read side
  output wire             rd_valid_out,
  input  wire             rd_ready_in,
  output wire [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wptr_reg;
  reg [AW-1:0]    rptr_reg;
  reg [AW:0]      cnt_reg;
  wire            do_wr;
  wire            do_rd;

  assign wr_ready_out = (cnt_reg != DEPTH[AW:0]);
  assign rd_valid_out = (cnt_reg != {(AW+1){1'b0}});
  assign rd_data_out  = mem_reg[rptr_reg];
  assign do_wr        = wr_valid_in & wr_ready_out;
  assign do_rd        = rd_valid_out & rd_ready_in;

  always @(posedge clk_in) begin
    if (do_wr) begin
      mem_reg[wptr_reg] <= wr_data_in;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      cnt_reg  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wptr_reg <= (wptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : wptr_reg + 1'b1;
      end
      if (do_rd) begin
        rptr_reg <= (rptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : rptr_reg + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_rd & ~do_wr) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/lwd_top.v */
// four-channel lin wake-up, mode and dominant timeout supervisor
`timescale 1ns/1ps
`default_nettype none
`include "lwd_defs.vh"
// Operation
// - bus wake-up is watched only in low power or standby mode.
// - wake needs falling edge, dominant for wake time, then recessive.
// - wake shows low on that receive output only when io supply good.
// - sleep-control low for local wake time is a wake request.
// - battery below power-off threshold forces off mode from any mode.
// - normal mode: recessive bus drives receive output high.
// - normal mode: transmit input high leaves bus output recessive.
// - transmit timeout timer restarts on each falling transmit edge.
// - transmit low beyond timeout disables that channel's transmitter.
// - transmit timeout timer clears when transmit input goes high.
// - bus dominant beyond timeout switches commander termination off.
// - weak responder pull-up stays on while commander termination off.
// - bus recessive again re-enables termination and clears its timer.
// - normal and standby modes enable the trimmed commander pull-up.
// - low power: parameter picks low-power pull-up or responder only.
// - sleep-control high in normal beyond go-to-sleep time: low power.
// - any channel wake in low power enters standby; others keep watching.
// - local wake in low power or standby enters normal mode.
// - off mode clears wake flags, ignores inputs, drivers off.
module lwd_top #(
  parameter LP_PULLUP_ON = 1,
  parameter WAKE_DOM_TK  = `LWD_WAKE_DOM_TK,
  parameter LOC_WAKE_TK  = `LWD_LOC_WAKE_TK,
  parameter SLEEP_TK     = `LWD_SLEEP_TK,
  parameter TXD_TO_TK    = `LWD_TXD_TO_TK,
  parameter BUS_TO_TK    = `LWD_BUS_TO_TK,
  parameter TICK_CYC     = `LWD_TICK_CYC
) (
  // clock and reset
  input  wire       clk_in,
  input  wire       rst_n_in,
  // supply monitors
  input  wire       battery_poff_in,
  input  wire       io_supply_ok_in,
  // controller side
  input  wire [3:0] transmit_input_in,
  input  wire       sleep_control_input_in,
  output reg  [3:0] receive_output_out,
  // bus side (bus_line_in 1 = recessive, bus_line_drive_out 1 = dominant)
  input  wire [3:0] bus_line_in,
  output reg  [3:0] bus_line_drive_out,
  output reg  [3:0] trim_pullup_en_out,
  output reg  [3:0] low_power_master_pullup_en_out,
  output reg  [3:0] responder_pullup_en_out,
  // status
  output reg  [1:0] mode_out,
  // wake event stream (channel mask), drained by the controller
  output reg        wake_evt_valid_out,
  output reg  [3:0] wake_evt_data_out,
  input  wire       wake_evt_ready_in
);
  reg  [1:0]  mode_reg;
  reg  [1:0]  mode_next;
  reg  [7:0]  tick_cnt_reg;
  reg         tick_reg;
  reg  [15:0] slp_cnt_reg;
  reg         slp_prev_reg;
  reg  [3:0]  bus_prev_reg;
  reg  [3:0]  txd_prev_reg;
  reg  [3:0]  wake_flag_reg;
  reg  [3:0]  wake_pend_reg;
  wire [3:0]  wake_hit;
  wire [3:0]  tx_dis;
  wire [3:0]  bus_to;
  wire        local_wake;
  wire        go_sleep;
  wire        in_on;
  wire        fifo_wr_ready;
  wire        fifo_rd_valid;
  wire [3:0]  fifo_rd_data;
  wire        fifo_rd_ready;

  assign in_on = (mode_reg != `LWD_MODE_OFF);

  // internal time base tick
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_reg <= 8'h00;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == TICK_CYC[7:0] - 8'h01);
      if (tick_cnt_reg == TICK_CYC[7:0] - 8'h01) begin
        tick_cnt_reg <= 8'h00;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 8'h01;
      end
    end
  end

  // sleep-control level duration counter, restarts on every level change
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slp_cnt_reg  <= 16'h0000;
      slp_prev_reg <= 1'b1;
    end else if (!in_on) begin
      slp_cnt_reg  <= 16'h0000;
      slp_prev_reg <= 1'b1;
    end else begin
      slp_prev_reg <= sleep_control_input_in;
      if (sleep_control_input_in != slp_prev_reg) begin
        slp_cnt_reg <= 16'h0000;
      end else if (tick_reg && slp_cnt_reg != 16'hFFFF) begin
        slp_cnt_reg <= slp_cnt_reg + 16'h0001;
      end
    end
  end

  assign local_wake = ~slp_prev_reg & ~sleep_control_input_in &
                      (slp_cnt_reg >= LOC_WAKE_TK[15:0]);
  assign go_sleep   = slp_prev_reg & sleep_control_input_in &
                      (slp_cnt_reg > SLEEP_TK[15:0]);

  // per-channel timers and wake detectors
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      reg [15:0] wk_cnt_reg;
      reg        wk_arm_reg;
      reg [15:0] tx_cnt_reg;
      reg        tx_dis_reg;
      reg [15:0] bd_cnt_reg;
      reg        bd_to_reg;
      wire       watch = (mode_reg == `LWD_MODE_LOWPWR) ||
                         (mode_reg == `LWD_MODE_STANDBY);
      assign wake_hit[g] = watch & wk_arm_reg & bus_line_in[g] &
                           (wk_cnt_reg >= WAKE_DOM_TK[15:0]);
      assign tx_dis[g]   = tx_dis_reg;
      assign bus_to[g]   = bd_to_reg;

      always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          wk_cnt_reg <= 16'h0000;
          wk_arm_reg <= 1'b0;
        end else if (!watch) begin
          wk_cnt_reg <= 16'h0000;
          wk_arm_reg <= 1'b0;
        end else if (bus_prev_reg[g] & ~bus_line_in[g]) begin
          wk_cnt_reg <= 16'h0000;
          wk_arm_reg <= 1'b1;
        end else if (bus_line_in[g]) begin
          wk_arm_reg <= 1'b0;
          wk_cnt_reg <= 16'h0000;
        end else if (tick_reg && wk_cnt_reg != 16'hFFFF) begin
          wk_cnt_reg <= wk_cnt_reg + 16'h0001;
        end
      end

      always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          tx_cnt_reg <= 16'h0000;
          tx_dis_reg <= 1'b0;
        end else if (mode_reg != `LWD_MODE_NORMAL ||
                     transmit_input_in[g]) begin
          tx_cnt_reg <= 16'h0000;
          tx_dis_reg <= 1'b0;
        end else if (txd_prev_reg[g]) begin
          tx_cnt_reg <= 16'h0000;
        end else if (tick_reg && !tx_dis_reg) begin
          tx_cnt_reg <= tx_cnt_reg + 16'h0001;
          if (tx_cnt_reg >= TXD_TO_TK[15:0]) begin
            tx_dis_reg <= 1'b1;
          end
        end
      end

      always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          bd_cnt_reg <= 16'h0000;
          bd_to_reg  <= 1'b0;
        end else if (!in_on || bus_line_in[g]) begin
          bd_cnt_reg <= 16'h0000;
          bd_to_reg  <= 1'b0;
        end else if (tick_reg && !bd_to_reg) begin
          bd_cnt_reg <= bd_cnt_reg + 16'h0001;
          if (bd_cnt_reg >= BUS_TO_TK[15:0]) begin
            bd_to_reg <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // mode state machine
  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      `LWD_MODE_OFF: begin
        mode_next = `LWD_MODE_NORMAL;
      end
      `LWD_MODE_NORMAL: begin
        if (go_sleep) begin
          mode_next = `LWD_MODE_LOWPWR;
        end
      end
      `LWD_MODE_LOWPWR: begin
        if (local_wake) begin
          mode_next = `LWD_MODE_NORMAL;
        end else if (|wake_hit) begin
          mode_next = `LWD_MODE_STANDBY;
        end
      end
      `LWD_MODE_STANDBY: begin
        if (local_wake) begin
          mode_next = `LWD_MODE_NORMAL;
        end
      end
      default: begin
        mode_next = `LWD_MODE_OFF;
      end
    endcase
    if (battery_poff_in) begin
      mode_next = `LWD_MODE_OFF;
    end
  end

  // wake event fifo towards the controller
  lwd_fifo #(
    .WIDTH (`LWD_FIFO_W),
    .DEPTH (`LWD_FIFO_D),
    .AW    (3)
  ) u_fifo (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .wr_valid_in  (|wake_pend_reg),
    .wr_ready_out (fifo_wr_ready),
    .wr_data_in   (wake_pend_reg),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (fifo_rd_ready),
    .rd_data_out  (fifo_rd_data)
  );
  // output stage holds one word; refill when empty or taken
  assign fifo_rd_ready = ~wake_evt_valid_out | wake_evt_ready_in;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg           <= `LWD_MODE_OFF;
      bus_prev_reg       <= 4'hF;
      txd_prev_reg       <= 4'hF;
      wake_flag_reg      <= 4'h0;
      wake_pend_reg      <= 4'h0;
      wake_evt_valid_out <= 1'b0;
      wake_evt_data_out  <= 4'h0;
    end else begin
      mode_reg     <= mode_next;
      bus_prev_reg <= bus_line_in;
      txd_prev_reg <= transmit_input_in;
      if (mode_next == `LWD_MODE_OFF || mode_next == `LWD_MODE_NORMAL) begin
        wake_flag_reg <= 4'h0;
      end else begin
        wake_flag_reg <= wake_flag_reg | wake_hit;
      end
      // pending events wait while the fifo is full
      if (fifo_wr_ready || ~|wake_pend_reg) begin
        wake_pend_reg <= wake_hit;
      end else begin
        wake_pend_reg <= wake_pend_reg | wake_hit;
      end
      if (fifo_rd_ready) begin
        wake_evt_valid_out <= fifo_rd_valid;
        wake_evt_data_out  <= fifo_rd_data;
      end
    end
  end

  // registered pin outputs
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      receive_output_out             <= 4'hF;
      bus_line_drive_out             <= 4'h0;
      trim_pullup_en_out             <= 4'h0;
      low_power_master_pullup_en_out <= 4'h0;
      responder_pullup_en_out        <= 4'h0;
      mode_out                       <= `LWD_MODE_OFF;
    end else begin
      mode_out                <= mode_reg;
      responder_pullup_en_out <= in_on ? 4'hF : 4'h0;
      case (mode_reg)
        `LWD_MODE_NORMAL: begin
          receive_output_out <= bus_line_in;
          // drive dominant only for low transmit not timed out
          bus_line_drive_out <= ~transmit_input_in & ~tx_dis &
                                {4{~sleep_control_input_in}};
          trim_pullup_en_out <= ~bus_to;
          low_power_master_pullup_en_out <= 4'h0;
        end
        `LWD_MODE_STANDBY: begin
          receive_output_out <= io_supply_ok_in ? ~wake_flag_reg
                                : 4'hF;
          bus_line_drive_out <= 4'h0;
          trim_pullup_en_out <= ~bus_to;
          low_power_master_pullup_en_out <= 4'h0;
        end
        `LWD_MODE_LOWPWR: begin
          receive_output_out <= io_supply_ok_in ? ~wake_flag_reg
                                : 4'hF;
          bus_line_drive_out <= 4'h0;
          trim_pullup_en_out <= 4'h0;
          low_power_master_pullup_en_out <=
            (LP_PULLUP_ON != 0) ? ~bus_to : 4'h0;
        end
        default: begin
          receive_output_out             <= 4'hF;
          bus_line_drive_out             <= 4'h0;
          trim_pullup_en_out             <= 4'h0;
          low_power_master_pullup_en_out <= 4'h0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* bench/lwd_top_sva.sv */
// port assertions for the lin wake and timeout supervisor
`timescale 1ns/1ps
`default_nettype none
`include "lwd_defs.vh"
module lwd_top_chk #(
  parameter LP_PULLUP_ON = 1
) (
  // clock, reset and supplies
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       battery_poff_in,
  input wire logic       io_supply_ok_in,
  // controller and bus sides
  input wire logic [3:0] transmit_input_in,
  input wire logic       sleep_control_input_in,
  input wire logic [3:0] receive_output_out,
  input wire logic [3:0] bus_line_in,
  input wire logic [3:0] bus_line_drive_out,
  input wire logic [3:0] trim_pullup_en_out,
  input wire logic [3:0] responder_pullup_en_out,
  input wire logic [1:0] mode_out
);
  logic [4:0] tx_cnt_reg;
  logic [4:0] bus_cnt_reg;
  logic       norm;
  assign norm = (mode_out == `LWD_MODE_NORMAL);
  // saturating low-time counters of channel 0
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_cnt_reg  <= 5'h00;
      bus_cnt_reg <= 5'h00;
    end else begin
      tx_cnt_reg  <= (norm && !transmit_input_in[0] && !sleep_control_input_in)
                     ? tx_cnt_reg + {4'h0, ~&tx_cnt_reg} : 5'h00;
      bus_cnt_reg <= !bus_line_in[0] ? bus_cnt_reg + {4'h0, ~&bus_cnt_reg}
                     : 5'h00;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_sleep_req;
    (norm && sleep_control_input_in) [*4];
  endsequence
  sequence s_loc_req;
    (mode_out[1] && !sleep_control_input_in) [*4];
  endsequence
  sequence s_bus_wake;
    (mode_out == `LWD_MODE_LOWPWR && bus_line_in[0]) ##1
    (mode_out == `LWD_MODE_LOWPWR && !bus_line_in[0]) [*7] ##1 bus_line_in[0];
  endsequence
  property p_off;
    mode_out == `LWD_MODE_OFF |-> bus_line_drive_out == 4'h0
      && trim_pullup_en_out == 4'h0;
  endproperty
  property p_resp;
    mode_out != `LWD_MODE_OFF |-> responder_pullup_en_out == 4'hF;
  endproperty
  property p_poff;
    battery_poff_in |-> ##[1:3] mode_out == `LWD_MODE_OFF;
  endproperty
  property p_rx;
    norm && $past(norm) |->
      (receive_output_out & $past(bus_line_in)) == $past(bus_line_in);
  endproperty
  property p_tx;
    norm && $past(norm) |->
      (bus_line_drive_out & $past(transmit_input_in)) == 4'h0;
  endproperty
  property p_txto;
    tx_cnt_reg >= 5'h10 |-> !bus_line_drive_out[0];
  endproperty
  property p_busto;
    bus_cnt_reg >= 5'h10 |-> !trim_pullup_en_out[0];
  endproperty
  property p_busrec;
    norm && $rose(bus_line_in[0]) |-> ##[1:3] trim_pullup_en_out[0];
  endproperty
  property p_sleep;
    s_sleep_req |-> ##[0:6] mode_out == `LWD_MODE_LOWPWR;
  endproperty
  property p_lwake;
    s_loc_req |-> ##[0:6] norm;
  endproperty
  property p_wake;
    s_bus_wake |-> ##[1:4] mode_out == `LWD_MODE_STANDBY
      ##[0:3] receive_output_out[0] == !io_supply_ok_in;
  endproperty
  a_off: assert property (p_off) else $error("drive on in off mode");
  a_resp: assert property (p_resp) else $error("responder off");
  a_poff: assert property (p_poff) else $error("off mode late");
  a_rx: assert property (p_rx) else $error("receive not high");
  a_tx: assert property (p_tx) else $error("drive while tx high");
  a_txto: assert property (p_txto) else $error("tx timeout late");
  a_busto: assert property (p_busto) else $error("bus timeout late");
  a_busrec: assert property (p_busrec) else $error("no pullup back");
  a_sleep: assert property (p_sleep) else $error("no low power");
  a_lwake: assert property (p_lwake) else $error("no local wake");
  a_wake: assert property (p_wake) else $error("no remote wake");
endmodule
bind lwd_top lwd_top_chk #(.LP_PULLUP_ON(LP_PULLUP_ON)) u_lwd_top_chk (.*);
`default_nettype wire

/* bench/lwd_ctrl_model.sv */
// controller model: transmit, sleep control and wake stream sink
`timescale 1ns/1ps
`default_nettype none
module lwd_ctrl_model (
  input  wire logic       clk_in,
  output var  logic [3:0] transmit_input_out,
  output var  logic       sleep_control_input_out,
  input  wire logic       wake_evt_valid_in,
  input  wire logic [3:0] wake_evt_data_in,
  output var  logic       wake_evt_ready_out
);
  initial begin
    transmit_input_out = 4'hF;
    sleep_control_input_out = 1'b0;
    wake_evt_ready_out = 1'b0;
  end
  // sleep level is held for n cycles and then left standing
  task automatic sleep_hold(input logic lvl, input int n);
    @(posedge clk_in) sleep_control_input_out <= lvl;
    repeat (n) @(posedge clk_in);
  endtask
  task automatic send(input logic [3:0] v);
    @(posedge clk_in) transmit_input_out <= v;
  endtask
  // ready stays up until the edge that takes a word
  task automatic take(output logic [3:0] d);
    @(posedge clk_in) wake_evt_ready_out <= 1'b1;
    do @(posedge clk_in); while (wake_evt_valid_in !== 1'b1);
    d = wake_evt_data_in;
    wake_evt_ready_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* bench/lwd_top_tb.sv */
// self-checking bench for the lin wake and timeout supervisor
`timescale 1ns/1ps
`default_nettype none
`include "lwd_defs.vh"
module lwd_top_tb;
  logic       clk_in, rst_n_in, battery_poff_in, io_supply_ok_in;
  logic       sleep_control_input, wrdy, wval;
  logic [3:0] bus_line_in, tx, wdat, rx, drv, trim, lpp, resp, got;
  logic [1:0] mode;
  int         miscompares = 0;
  int         compares = 0;
  int         cyc = 0;
  lwd_top #(
    .WAKE_DOM_TK(3), .LOC_WAKE_TK(3), .SLEEP_TK(3),
    .TXD_TO_TK(10), .BUS_TO_TK(10), .TICK_CYC(1)
  ) u_lwd_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .battery_poff_in(battery_poff_in), .io_supply_ok_in(io_supply_ok_in),
    .transmit_input_in(tx), .sleep_control_input_in(sleep_control_input),
    .receive_output_out(rx), .bus_line_in(bus_line_in),
    .bus_line_drive_out(drv), .trim_pullup_en_out(trim),
    .low_power_master_pullup_en_out(lpp), .responder_pullup_en_out(resp),
    .mode_out(mode), .wake_evt_valid_out(wval),
    .wake_evt_data_out(wdat), .wake_evt_ready_in(wrdy)
  );
  lwd_ctrl_model u_lwd_ctrl_model (
    .clk_in(clk_in), .transmit_input_out(tx),
    .sleep_control_input_out(sleep_control_input), .wake_evt_valid_in(wval),
    .wake_evt_data_in(wdat), .wake_evt_ready_out(wrdy)
  );
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic final_report();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic bus(input logic [3:0] v, input int n);
    @(posedge clk_in) bus_line_in <= v;
    step(n);
  endtask
  task automatic wmode(input logic [1:0] m);
    for (int i = 0; i < 60 && mode !== m; i++) @(posedge clk_in);
    chk({2'h0, mode}, {2'h0, m});
  endtask
  task automatic t_reset();
    wmode(`LWD_MODE_NORMAL);
    step(2);
    chk(resp, 4'hF);
    chk(trim, 4'hF);
    $display("reset test done");
  endtask
  task automatic t_norm();
    bus(4'h5, 3);
    chk(rx, 4'h5);
    chk(drv, 4'h0);
    u_lwd_ctrl_model.send(4'h5);
    bus(4'hF, 3);
    chk(drv, 4'hA);
    u_lwd_ctrl_model.send(4'hF);
    $display("normal test done");
  endtask
  task automatic t_txto();
    repeat (3) begin
      u_lwd_ctrl_model.send(4'hF);
      u_lwd_ctrl_model.send(4'hE);
      step(7);
      chk(drv, 4'h1);
    end
    step(20);
    chk(drv, 4'h0);
    u_lwd_ctrl_model.send(4'hF);
    step(3);
    chk(drv, 4'h0);
    $display("transmit timeout test done");
  endtask
  task automatic t_busto();
    bus(4'hE, 20);
    chk(trim, 4'hE);
    chk(resp, 4'hF);
    bus(4'hF, 4);
    chk(trim, 4'hF);
    chk({3'h0, wval}, 4'h0);
    $display("bus timeout test done");
  endtask
  task automatic t_sleep_wake();
    u_lwd_ctrl_model.sleep_hold(1'b1, 12);
    wmode(`LWD_MODE_LOWPWR);
    chk(trim, 4'h0);
    chk(lpp, 4'hF);
    bus(4'hE, 2);
    bus(4'hF, 6);
    chk({2'h0, mode}, {2'h0, `LWD_MODE_LOWPWR});
    bus(4'hE, 6);
    bus(4'hF, 1);
    wmode(`LWD_MODE_STANDBY);
    step(3);
    chk(rx, 4'hE);
    chk(trim, 4'hF);
    bus(4'hB, 6);
    bus(4'hF, 5);
    chk(rx, 4'hA);
    // io supply below recovery hides the wake indication
    @(posedge clk_in) io_supply_ok_in <= 1'b0;
    step(2);
    chk(rx, 4'hF);
    @(posedge clk_in) io_supply_ok_in <= 1'b1;
    step(2);
    chk(rx, 4'hA);
    u_lwd_ctrl_model.take(got);
    chk(got, 4'h1);
    u_lwd_ctrl_model.take(got);
    chk(got, 4'h4);
    u_lwd_ctrl_model.sleep_hold(1'b0, 8);
    wmode(`LWD_MODE_NORMAL);
    step(3);
    chk(rx, 4'hF);
    $display("sleep and wake test done");
  endtask
  task automatic t_poff();
    @(posedge clk_in) battery_poff_in <= 1'b1;
    wmode(`LWD_MODE_OFF);
    u_lwd_ctrl_model.send(4'h0);
    step(4);
    chk(drv, 4'h0);
    chk(resp, 4'h0);
    @(posedge clk_in) battery_poff_in <= 1'b0;
    u_lwd_ctrl_model.send(4'hF);
    wmode(`LWD_MODE_NORMAL);
    $display("power off test done");
  endtask
  initial begin
    rst_n_in = 1'b0;
    battery_poff_in = 1'b0;
    io_supply_ok_in = 1'b1;
    bus_line_in = 4'hF;
    step(10);
    rst_n_in <= 1'b1;
    t_reset();
    t_norm();
    t_txto();
    t_busto();
    t_sleep_wake();
    t_poff();
    final_report();
  end
endmodule
`default_nettype wire
